// file: include/pocl_map.svh
// Offsets, fields, reset values and timing for the port block
`ifndef POCL_MAP_SVH
`define POCL_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define POCL_OFS_P0_LATCH 8'h00
`define POCL_OFS_P1_LATCH 8'h04
`define POCL_OFS_P2_LATCH 8'h08
`define POCL_OFS_P0_MODE_LO 8'h0C
`define POCL_OFS_P0_MODE_HI 8'h10
`define POCL_OFS_P1_MODE_LO 8'h14
`define POCL_OFS_P1_MODE_HI 8'h18
`define POCL_OFS_P2_MODE_LO 8'h1C
`define POCL_OFS_P2_MODE_HI 8'h20
`define POCL_OFS_P0_PIN 8'h24
`define POCL_OFS_P1_PIN 8'h28
`define POCL_OFS_P2_PIN 8'h2C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define POCL_BIT_T0_TOGGLE 2
`define POCL_BIT_T1_TOGGLE 3
`define POCL_BIT_CLK_OUT 4
`define POCL_BIT_P0_SCHMITT 5
`define POCL_BIT_P1_SCHMITT 6
`define POCL_BIT_P2_SCHMITT 7
`define POCL_PIN_FIXED_OD_A 2
`define POCL_PIN_FIXED_OD_B 3
`define POCL_PIN_RESET_SHARED 5
`define POCL_PIN_OSC_A 0
`define POCL_PIN_OSC_B 1

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define POCL_MODE_RESET 8'h00
`define POCL_STRONG_PULSE_CLKS 2
`define POCL_RESP_OKAY 2'h0
`define POCL_RESP_SLVERR 2'h2

`endif

// file: include/pocl_pkg.sv
// Types shared by the port output configuration block
package pocl_pkg;

    typedef enum logic [1:0] {
        POCL_QUASI,
        POCL_PUSH_PULL,
        POCL_INPUT_ONLY,
        POCL_OPEN_DRAIN
    } pocl_mode_e;

    typedef logic [7:0] pocl_byte_t;

endpackage : pocl_pkg

// file: rtl/pocl_pin_drv.sv
// Per-pin driver control for one port pin
`include "pocl_map.svh"

module pocl_pin_drv (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    // Configuration
    input wire logic mode_lo,
    input wire logic mode_hi,
    input wire logic force_od,
    input wire logic disable_pin,
    // Pin state
    input wire logic latch,
    input wire logic pin_level,
    // Driver enables
    output logic very_weak_pu_q,
    output logic weak_pu_q,
    output logic strong_pu_q,
    output logic pull_dn_q
);
    import pocl_pkg::*;

    pocl_mode_e mode;
    logic latch_prev_q, latch_prev_d;
    logic [1:0] pulse_q, pulse_d;
    logic vw_d, wk_d, st_d, pd_d;

    // ------------------------------------------------------------
    // Mode decode and driver selection
    // ------------------------------------------------------------
    always_comb begin
        if (force_od) begin
            mode = POCL_OPEN_DRAIN;
        end else begin
            mode = pocl_mode_e'({mode_lo, mode_hi});
        end
        latch_prev_d = latch;
        pulse_d = (pulse_q != 2'h0) ? pulse_q - 2'h1 : 2'h0;
        if (mode == POCL_QUASI && latch && !latch_prev_q) begin
            pulse_d = 2'(`POCL_STRONG_PULSE_CLKS);
        end
        if (mode != POCL_QUASI) begin
            pulse_d = 2'h0;
        end
        vw_d = 1'b0;
        wk_d = 1'b0;
        st_d = 1'b0;
        pd_d = 1'b0;
        case (mode)
            POCL_QUASI: begin
                vw_d = latch;
                wk_d = latch && pin_level;
                st_d = pulse_d != 2'h0;
                pd_d = !latch;
            end
            POCL_PUSH_PULL: begin
                st_d = latch;
                pd_d = !latch;
            end
            POCL_OPEN_DRAIN: begin
                pd_d = !latch;
            end
            POCL_INPUT_ONLY: begin
                pd_d = 1'b0;
            end
            default: begin
                pd_d = 1'b0;
            end
        endcase
        if (disable_pin) begin
            vw_d = 1'b0;
            wk_d = 1'b0;
            st_d = 1'b0;
            pd_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            latch_prev_q <= 1'b0;
            pulse_q <= 2'h0;
            very_weak_pu_q <= 1'b0;
            weak_pu_q <= 1'b0;
            strong_pu_q <= 1'b0;
            pull_dn_q <= 1'b0;
        end else if (clk_en) begin
            latch_prev_q <= latch_prev_d;
            pulse_q <= pulse_d;
            very_weak_pu_q <= vw_d;
            weak_pu_q <= wk_d;
            strong_pu_q <= st_d;
            pull_dn_q <= pd_d;
        end
    end

endmodule : pocl_pin_drv

// file: rtl/pocl_port.sv
// One eight-pin port: driver control and input buffer selection
`include "pocl_map.svh"

module pocl_port #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    // Configuration
    input wire logic [WIDTH-1:0] mode_lo,
    input wire logic [WIDTH-1:0] mode_hi,
    input wire logic [WIDTH-1:0] force_od,
    input wire logic [WIDTH-1:0] disable_pin,
    input wire logic [WIDTH-1:0] force_schmitt,
    input wire logic schmitt_sel,
    // Pin state
    input wire logic [WIDTH-1:0] latch,
    input wire logic [WIDTH-1:0] pin_level,
    // Outputs
    output logic [WIDTH-1:0] very_weak_pu,
    output logic [WIDTH-1:0] weak_pu,
    output logic [WIDTH-1:0] strong_pu,
    output logic [WIDTH-1:0] pull_dn,
    output logic [WIDTH-1:0] schmitt_en,
    output logic [WIDTH-1:0] input_en
);
    import pocl_pkg::*;

    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("port width out of range");
    end

    // ------------------------------------------------------------
    // Pin drivers and input selection
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        pocl_pin_drv u_drv (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .clk_en(clk_en),
            .mode_lo(mode_lo[i]),
            .mode_hi(mode_hi[i]),
            .force_od(force_od[i]),
            .disable_pin(disable_pin[i]),
            .latch(latch[i]),
            .pin_level(pin_level[i]),
            .very_weak_pu_q(very_weak_pu[i]),
            .weak_pu_q(weak_pu[i]),
            .strong_pu_q(strong_pu[i]),
            .pull_dn_q(pull_dn[i])
        );
    end

    logic [WIDTH-1:0] sch_d, sch_q, ien_d, ien_q;
    always_comb begin
        sch_d = {WIDTH{schmitt_sel}} | force_schmitt;
        ien_d = ~disable_pin;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sch_q <= '0;
            ien_q <= '1;
        end else if (clk_en) begin
            sch_q <= sch_d;
            ien_q <= ien_d;
        end
    end

    assign schmitt_en = sch_q;
    assign input_en = ien_q;

endmodule : pocl_port

// file: rtl/pocl_top.sv
// Port output configuration logic for three ports with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`include "pocl_map.svh"

module pocl_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    // Option straps
    input wire logic reset_level_select,
    input wire logic crystal_osc_sel,
    input wire logic internal_reset_sel,
    // Pins
    input wire pocl_pkg::pocl_byte_t pin_p0,
    input wire pocl_pkg::pocl_byte_t pin_p1,
    input wire pocl_pkg::pocl_byte_t pin_p2,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Driver enables {p2,p1,p0}
    output logic [23:0] very_weak_pu,
    output logic [23:0] weak_pu,
    output logic [23:0] strong_pu,
    output logic [23:0] pull_dn,
    output logic [23:0] schmitt_en,
    output logic [23:0] input_en,
    // Auxiliary enables
    output logic t0_toggle_en,
    output logic t1_toggle_en,
    output logic clk_out_en
);
    import pocl_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    pocl_byte_t latch_q [3];
    pocl_byte_t latch_d [3];
    pocl_byte_t mlo_q [3];
    pocl_byte_t mlo_d [3];
    pocl_byte_t mhi_q [3];
    pocl_byte_t mhi_d [3];
    logic init_q, init_d;
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d, ara_q, ara_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic aux_t0_q, aux_t1_q, aux_ck_q;
    logic awr_q, wr_q, arr_q;

    // Read mux; pin offsets show live levels
    function automatic logic [32:0] rd_word(input logic [7:0] a, input pocl_byte_t l0,
        input pocl_byte_t l1, input pocl_byte_t l2, input pocl_byte_t p0,
        input pocl_byte_t p1, input pocl_byte_t p2, input pocl_byte_t ml0,
        input pocl_byte_t mh0, input pocl_byte_t ml1, input pocl_byte_t mh1,
        input pocl_byte_t ml2, input pocl_byte_t mh2);
        logic [32:0] r;
        r = 33'h000000000;
        case (a)
            `POCL_OFS_P0_LATCH: r[7:0] = l0;
            `POCL_OFS_P1_LATCH: r[7:0] = l1;
            `POCL_OFS_P2_LATCH: r[7:0] = l2;
            `POCL_OFS_P0_MODE_LO: r[7:0] = ml0;
            `POCL_OFS_P0_MODE_HI: r[7:0] = mh0;
            `POCL_OFS_P1_MODE_LO: r[7:0] = ml1;
            `POCL_OFS_P1_MODE_HI: r[7:0] = mh1;
            `POCL_OFS_P2_MODE_LO: r[7:0] = ml2;
            `POCL_OFS_P2_MODE_HI: r[7:0] = mh2;
            `POCL_OFS_P0_PIN: r[7:0] = p0;
            `POCL_OFS_P1_PIN: r[7:0] = p1;
            `POCL_OFS_P2_PIN: r[7:0] = p2;
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction : rd_word

    // ------------------------------------------------------------
    // Bus and register next state
    // ------------------------------------------------------------
    always_comb begin
        logic [32:0] rw;
        logic [7:0] wb;
        logic ok;
        rw = 33'h000000000;
        wb = 8'h00;
        ok = 1'b0;
        latch_d = latch_q;
        mlo_d = mlo_q;
        mhi_d = mhi_q;
        init_d = 1'b1;
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        // Reset level loaded after release
        if (!init_q) begin
            for (int p = 0; p < 3; p++) begin
                latch_d[p] = {8{reset_level_select}};
            end
        end
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
        end
        if (aw_q && w_q && !bv_q) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            wb = wd_q[7:0];
            ok = 1'b1;
            case (awa_q)
                `POCL_OFS_P0_LATCH: latch_d[0] = wb;
                `POCL_OFS_P1_LATCH: latch_d[1] = wb;
                `POCL_OFS_P2_LATCH: latch_d[2] = wb;
                `POCL_OFS_P0_MODE_LO: mlo_d[0] = wb;
                `POCL_OFS_P0_MODE_HI: mhi_d[0] = wb;
                `POCL_OFS_P1_MODE_LO: mlo_d[1] = wb;
                `POCL_OFS_P1_MODE_HI: mhi_d[1] = wb;
                `POCL_OFS_P2_MODE_LO: mlo_d[2] = wb;
                `POCL_OFS_P2_MODE_HI: mhi_d[2] = wb;
                `POCL_OFS_P0_PIN, `POCL_OFS_P1_PIN, `POCL_OFS_P2_PIN: ok = 1'b1;
                default: ok = 1'b0;
            endcase
            br_d = ok ? `POCL_RESP_OKAY : `POCL_RESP_SLVERR;
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        if (s_axi_arvalid && !rv_q) begin
            rw = rd_word(s_axi_araddr, latch_q[0], latch_q[1], latch_q[2], pin_p0, pin_p1,
                pin_p2, mlo_q[0], mhi_q[0], mlo_q[1], mhi_q[1], mlo_q[2], mhi_q[2]);
            rv_d = 1'b1;
            rd_d = rw[31:0];
            rr_d = rw[32] ? `POCL_RESP_SLVERR : `POCL_RESP_OKAY;
        end
        if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < 3; p++) begin
                latch_q[p] <= 8'h00;
                mlo_q[p] <= `POCL_MODE_RESET;
                mhi_q[p] <= `POCL_MODE_RESET;
            end
            init_q <= 1'b0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h00000000;
            bv_q <= 1'b0;
            br_q <= 2'h0;
            rv_q <= 1'b0;
            rd_q <= 32'h00000000;
            rr_q <= 2'h0;
            aux_t0_q <= 1'b0;
            aux_t1_q <= 1'b0;
            aux_ck_q <= 1'b0;
            awr_q <= 1'b1;
            wr_q <= 1'b1;
            arr_q <= 1'b1;
        end else if (clk_en) begin
            latch_q <= latch_d;
            mlo_q <= mlo_d;
            mhi_q <= mhi_d;
            init_q <= init_d;
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            aux_t0_q <= mlo_d[2][`POCL_BIT_T0_TOGGLE];
            aux_t1_q <= mlo_d[2][`POCL_BIT_T1_TOGGLE];
            aux_ck_q <= mlo_d[2][`POCL_BIT_CLK_OUT];
            awr_q <= !aw_d;
            wr_q <= !w_d;
            arr_q <= !rv_d;
        end
    end

    assign s_axi_awready = awr_q;
    assign s_axi_wready = wr_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = arr_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign t0_toggle_en = aux_t0_q;
    assign t1_toggle_en = aux_t1_q;
    assign clk_out_en = aux_ck_q;

    // ------------------------------------------------------------
    // Port instances and pin exceptions
    // ------------------------------------------------------------
    pocl_byte_t p1_force_od, p1_force_sch, p2_dis, p2_mlo;
    pocl_byte_t pins [3];
    logic [2:0] sch_sel;

    always_comb begin
        p1_force_od = 8'h00;
        p1_force_od[`POCL_PIN_FIXED_OD_A] = 1'b1;
        p1_force_od[`POCL_PIN_FIXED_OD_B] = 1'b1;
        p1_force_sch = p1_force_od;
        // Reset pin always Schmitt
        p1_force_sch[`POCL_PIN_RESET_SHARED] = 1'b1;
        p2_dis = 8'h00;
        p2_dis[`POCL_PIN_OSC_A] = crystal_osc_sel;
        p2_dis[`POCL_PIN_OSC_B] = crystal_osc_sel;
        p2_mlo = 8'h00;
        p2_mlo[1:0] = mlo_q[2][1:0];
        sch_sel[0] = mlo_q[2][`POCL_BIT_P0_SCHMITT];
        sch_sel[1] = mlo_q[2][`POCL_BIT_P1_SCHMITT];
        sch_sel[2] = mlo_q[2][`POCL_BIT_P2_SCHMITT];
        pins[0] = pin_p0;
        pins[1] = pin_p1;
        pins[2] = pin_p2;
    end

    pocl_byte_t fod [3];
    pocl_byte_t dis [3];
    pocl_byte_t fsch [3];
    pocl_byte_t mlo_use [3];
    always_comb begin
        fod[0] = 8'h00;
        fod[1] = p1_force_od;
        fod[2] = 8'h00;
        dis[0] = 8'h00;
        dis[1] = 8'h00;
        dis[1][`POCL_PIN_RESET_SHARED] = !internal_reset_sel;
        dis[2] = p2_dis;
        fsch[0] = 8'h00;
        fsch[1] = p1_force_sch;
        fsch[2] = 8'h00;
        mlo_use[0] = mlo_q[0];
        mlo_use[1] = mlo_q[1];
        mlo_use[2] = p2_mlo;
    end

    for (genvar p = 0; p < 3; p++) begin : g_port
        pocl_port #(.WIDTH(8)) u_port (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .clk_en(clk_en),
            .mode_lo(mlo_use[p]),
            .mode_hi(mhi_q[p]),
            .force_od(fod[p]),
            .disable_pin(dis[p]),
            .force_schmitt(fsch[p]),
            .schmitt_sel(sch_sel[p]),
            .latch(latch_q[p]),
            .pin_level(pins[p]),
            .very_weak_pu(very_weak_pu[p*8 +: 8]),
            .weak_pu(weak_pu[p*8 +: 8]),
            .strong_pu(strong_pu[p*8 +: 8]),
            .pull_dn(pull_dn[p*8 +: 8]),
            .schmitt_en(schmitt_en[p*8 +: 8]),
            .input_en(input_en[p*8 +: 8])
        );
    end

endmodule : pocl_top

// file: dv/pocl_top_sva.sv
// Checker for the port block enables
module pocl_top_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    // Straps and pins
    input wire logic crystal_osc_sel,
    input wire logic internal_reset_sel,
    input wire pocl_pkg::pocl_byte_t pin_p0,
    input wire pocl_pkg::pocl_byte_t pin_p1,
    input wire pocl_pkg::pocl_byte_t pin_p2,
    // Enables
    input wire logic [23:0] very_weak_pu,
    input wire logic [23:0] weak_pu,
    input wire logic [23:0] strong_pu,
    input wire logic [23:0] pull_dn,
    input wire logic [23:0] schmitt_en,
    input wire logic [23:0] input_en
);
    import pocl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic live_q;
    logic [23:0] pins;
    assign pins = {pin_p2, pin_p1, pin_p0};
    // ------------------------------------------------------------
    // Outputs lag one edge: skip first edge
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            live_q <= 1'b0;
        end else begin
            live_q <= clk_en;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    no_fight_a: assert property (((very_weak_pu | weak_pu | strong_pu) & pull_dn) == 24'h0)
        else $error("pull fight");
    weak_needs_vw_a: assert property ((weak_pu & ~very_weak_pu) == 24'h0)
        else $error("weak without very weak");
    weak_pin_a: assert property (live_q |-> (weak_pu & ~$past(pins)) == 24'h0)
        else $error("weak on low pin");
    fixed_od_a: assert property (((very_weak_pu | weak_pu | strong_pu) & 24'h000C00) == 24'h0)
        else $error("pull-up on fixed pin");
    strong_pulse_a: assert property ($rose(strong_pu[0]) && very_weak_pu[0] ##0 clk_en [*2]
        |-> strong_pu[0] ##1 !strong_pu[0])
        else $error("strong pulse length");
    osc_off_a: assert property (live_q && $past(crystal_osc_sel)
        |-> {input_en[17:16], very_weak_pu[17:16], strong_pu[17:16], pull_dn[17:16]} == 8'h00)
        else $error("osc pins active");
    rst_pin_a: assert property (live_q |-> input_en[13] == $past(internal_reset_sel))
        else $error("reset pin input");
    schmitt_fix_a: assert property (live_q |-> schmitt_en[13] && schmitt_en[11] && schmitt_en[10])
        else $error("fixed pin Schmitt");
    schmitt_port_a: assert property (live_q |-> schmitt_en[7:0] inside {8'h00, 8'hFF})
        else $error("port 0 Schmitt mixed");
    cover property ($rose(strong_pu[0]) && very_weak_pu[0]);
    cover property (live_q && $past(crystal_osc_sel));
    cover property (schmitt_en[7:0] == 8'hFF);
endmodule : pocl_top_sva

bind pocl_top pocl_top_sva u_pocl_top_sva (
    .clk_sys, .nrst, .clk_en, .crystal_osc_sel, .internal_reset_sel, .pin_p0, .pin_p1, .pin_p2,
    .very_weak_pu, .weak_pu, .strong_pu, .pull_dn, .schmitt_en, .input_en
);

// file: dv/pocl_pin_model.sv
// Board circuitry on the port pins
module pocl_pin_model (
    // Clock
    input wire logic clk_sys,
    // Block drivers and board devices
    input wire logic [23:0] very_weak_pu,
    input wire logic [23:0] weak_pu,
    input wire logic [23:0] strong_pu,
    input wire logic [23:0] pull_dn,
    input wire logic [23:0] ext_dn,
    input wire logic [23:0] ext_pu,
    // Sensed levels
    output pocl_pkg::pocl_byte_t pin_p0,
    output pocl_pkg::pocl_byte_t pin_p1,
    output pocl_pkg::pocl_byte_t pin_p2
);
    import pocl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] lvl;
    logic [23:0] float_q = 24'h000000;
    // Floating pins toggle
    always_ff @(posedge clk_sys) begin
        float_q <= ~lvl;
    end
    // Sinks win; board resistors pull up
    assign lvl = ~(pull_dn | ext_dn) & (very_weak_pu | weak_pu | strong_pu | ext_pu | float_q);
    assign {pin_p2, pin_p1, pin_p0} = lvl;
endmodule : pocl_pin_model

// file: dv/tb_top.sv
// Self-checking bench for the port block
`include "pocl_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pocl_pkg::*;
    logic clk_sys, nrst = 1'b0, clk_en = 1'b1, reset_level_select = 1'b1;
    logic crystal_osc_sel = 1'b0, internal_reset_sel = 1'b1;
    pocl_byte_t pin_p0, pin_p1, pin_p2;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [23:0] very_weak_pu, weak_pu, strong_pu, pull_dn, schmitt_en, input_en;
    logic [23:0] ext_dn = 24'h000000, ext_pu = 24'h000C00;
    logic t0_toggle_en, t1_toggle_en, clk_out_en, pd;
    logic [3:0] exp4;
    pocl_mode_e m;
    int error_cnt = 0, cmp_count = 0, cyc = 0, st_cnt = 0;

    pocl_top u_pocl_top (
        .clk_sys, .nrst, .clk_en, .reset_level_select, .crystal_osc_sel, .internal_reset_sel,
        .pin_p0, .pin_p1, .pin_p2, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .very_weak_pu, .weak_pu, .strong_pu, .pull_dn, .schmitt_en, .input_en,
        .t0_toggle_en, .t1_toggle_en, .clk_out_en
    );
    pocl_pin_model u_pocl_pin_model (.clk_sys, .very_weak_pu, .weak_pu, .strong_pu, .pull_dn,
        .ext_dn, .ext_pu, .pin_p0, .pin_p1, .pin_p2);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // Watchdog, strong pulse count
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        cyc++;
        if (strong_pu[0] === 1'b1) st_cnt++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(32'(s_axi_rresp), 32'(er));
        if (er == `POCL_RESP_OKAY) chk(s_axi_rdata, exp);
    endtask : axi_rd
    task automatic do_reset(input logic lvl);
        nrst <= 1'b0;
        reset_level_select <= lvl;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : do_reset
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        axi_rd(`POCL_OFS_P0_LATCH, 32'hFF, `POCL_RESP_OKAY);
        axi_rd(`POCL_OFS_P1_MODE_HI, 32'h0, `POCL_RESP_OKAY);
        chk(32'(very_weak_pu), 32'hFFF3FF);
        chk(32'(weak_pu), 32'hFFF3FF);
        axi_rd(`POCL_OFS_P0_PIN, 32'hFF, `POCL_RESP_OKAY);
        $display("reset level test done");
        for (int i = 0; i < 4; i++) begin
            m = pocl_mode_e'(i);
            ext_pu[0] <= (m == POCL_INPUT_ONLY || m == POCL_OPEN_DRAIN);
            axi_wr(`POCL_OFS_P0_MODE_LO, {31'h0, i[1]}, `POCL_RESP_OKAY);
            axi_wr(`POCL_OFS_P0_MODE_HI, {31'h0, i[0]}, `POCL_RESP_OKAY);
            for (int l = 0; l < 2; l++) begin
                st_cnt = 0;
                axi_wr(`POCL_OFS_P0_LATCH, l ? 32'hFF : 32'h0, `POCL_RESP_OKAY);
                repeat (6) @(posedge clk_sys);
                pd = (m != POCL_INPUT_ONLY) && l == 0;
                exp4 = {m == POCL_QUASI && l == 1, m == POCL_QUASI && l == 1,
                    m == POCL_PUSH_PULL && l == 1, pd};
                chk(32'({very_weak_pu[0], weak_pu[0], strong_pu[0], pull_dn[0]}), 32'(exp4));
                if (m != POCL_PUSH_PULL) chk(32'(st_cnt), (m == POCL_QUASI && l == 1) ? 2 : 0);
                axi_rd(`POCL_OFS_P0_PIN, 32'({{7{l[0]}}, !pd}), `POCL_RESP_OKAY);
            end
        end
        ext_dn[1] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(32'({very_weak_pu[1], weak_pu[1]}), 32'h2);
        ext_dn[1] <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(32'(weak_pu[1]), 32'h1);
        $display("mode test done");
        axi_wr(`POCL_OFS_P1_MODE_HI, 32'hFF, `POCL_RESP_OKAY);
        axi_wr(`POCL_OFS_P1_LATCH, 32'h0, `POCL_RESP_OKAY);
        repeat (3) @(posedge clk_sys);
        chk(32'(pull_dn[11:10]), 32'h3);
        axi_wr(`POCL_OFS_P1_LATCH, 32'hFF, `POCL_RESP_OKAY);
        ext_dn[10] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(32'(strong_pu[15:8] & 8'hDF), 32'hD3);
        chk(32'(pull_dn[11:10]), 32'h0);
        axi_rd(`POCL_OFS_P1_PIN, 32'hFB, `POCL_RESP_OKAY);
        ext_dn[10] <= 1'b0;
        axi_wr(`POCL_OFS_P2_MODE_LO, 32'hFC, `POCL_RESP_OKAY);
        repeat (3) @(posedge clk_sys);
        chk(32'({schmitt_en, t0_toggle_en, t1_toggle_en, clk_out_en}), 32'h7FFFFFF);
        axi_wr(`POCL_OFS_P2_MODE_LO, 32'h20, `POCL_RESP_OKAY);
        repeat (3) @(posedge clk_sys);
        chk(32'({schmitt_en, t0_toggle_en, t1_toggle_en, clk_out_en}), 32'h00167F8);
        axi_rd(`POCL_OFS_P2_MODE_LO, 32'h20, `POCL_RESP_OKAY);
        $display("fixed pin test done");
        crystal_osc_sel <= 1'b1;
        internal_reset_sel <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(32'({input_en[17:16], input_en[13], very_weak_pu[17:16], pull_dn[17:16]}), 32'h0);
        crystal_osc_sel <= 1'b0;
        internal_reset_sel <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(32'({input_en[17:16], input_en[13]}), 32'h7);
        $display("strap pin test done");
        axi_wr(8'h40, 32'hFF, `POCL_RESP_SLVERR);
        axi_rd(8'h40, 32'h0, `POCL_RESP_SLVERR);
        axi_wr(`POCL_OFS_P0_PIN, 32'h0, `POCL_RESP_OKAY);
        axi_rd(`POCL_OFS_P0_LATCH, 32'hFF, `POCL_RESP_OKAY);
        $display("bus refusal test done");
        do_reset(1'b0);
        axi_rd(`POCL_OFS_P2_LATCH, 32'h0, `POCL_RESP_OKAY);
        chk(32'(pull_dn), 32'hFFFFFF);
        $display("low reset level test done");
        print_verdict();
    end
endmodule : tb_top
